// ===== hw/spe_entry.sv
// Serial programming entry logic: recognises high- and low-voltage entry,
// checks the low-voltage key and streams session bytes into a FIFO.
// Assumes pins arrive asynchronously; serial clock well below core_clk.
// The clear pin is active low; the high-voltage level comes from a comparator.
`timescale 1ns/10ps
module spe_entry (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     prog_serial_clock,
  input  wire logic                     prog_serial_data_in,
  output logic                          prog_serial_data_out,
  output logic                          prog_serial_data_oe_b,
  input  wire logic                     master_clear_prog_voltage_pin_b,
  input  wire logic                     high_voltage_entry_level,
  input  wire logic                     low_voltage_entry_enable,
  input  wire logic                     clearEntryEnableReq,
  input  wire logic                     readBitValid,
  input  wire logic                     readBit,
  input  wire logic                     readyForWord,
  output logic                          lowVoltageEntryClearOk,
  output logic                          masterClearResetEnable,
  output logic                          progMode,
  output logic                          progHighVoltage,
  output logic [spe_pkg::WORD_W-1:0]    progWord,
  output logic                          progWordValid,
  output logic                          progOverflow
);
  import spe_pkg::*;

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  logic [3:0] pinSync;
  logic       sclk;
  logic       sdat;
  logic       mclrB;
  logic       hvLevel;
  logic       sclkLast;
  logic       sclkFall;

  spe_sync #(.WIDTH(4)) uSync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinIn    ({high_voltage_entry_level, !master_clear_prog_voltage_pin_b,
                prog_serial_data_in, prog_serial_clock}),
    .pinSync  (pinSync)
  );
  // Two stages of lag mean a serial edge is acted on three cycles late.

  assign sclk    = pinSync[0];
  assign sdat    = pinSync[1];
  // The clear pin travels inverted, so the synchroniser's reset value reads as
  // released; a raw copy would show a low pin and start a false key entry.
  assign mclrB   = !pinSync[2];
  assign hvLevel = pinSync[3];
  assign sclkFall = !sclk && sclkLast;

  // ==========================================================================
  // Entry state machine
  // ==========================================================================
  spe_state_t             state;
  spe_state_t             next_state;
  logic [KEY_BITS-1:0]    keyShift;
  logic [KEY_BITS-1:0]    next_keyShift;
  logic [CNT_W-1:0]       keyCount;
  logic [CNT_W-1:0]       next_keyCount;
  logic                   hvPrev;
  logic                   hvRise;
  logic                   quietPins;

  // Entry needs a fresh rise of the level, so a level left high cannot re-enter.
  assign hvRise    = hvLevel && !hvPrev;
  assign quietPins = !sclk && !sdat;

  always_comb begin
    next_state    = state;
    next_keyShift = keyShift;
    next_keyCount = keyCount;
    case (state)
      SPE_IDLE: begin
        next_keyCount = CNT_ZERO;
        if (hvRise && quietPins) begin
          next_state = SPE_HV_PROG;
        end else if (!mclrB && low_voltage_entry_enable && !hvLevel) begin
          next_state = SPE_KEY;
        end
      end
      SPE_KEY: begin
        if (mclrB || !low_voltage_entry_enable) begin
          next_state = SPE_IDLE;
        end else if (keyCount == KEY_LAST) begin
          // The compare waits one cycle after the last fall so the final bit has landed.
          // Key compare.
          next_state = (keyShift == ENTRY_KEY) ? SPE_LV_PROG : SPE_LOCKED;
        end else if (sclkFall) begin
          next_keyShift = {keyShift[KEY_BITS-2:0], sdat};
          next_keyCount = keyCount + 6'h01;
        end
      end
      SPE_LV_PROG: begin
        if (mclrB) begin
          next_state = SPE_IDLE;
        end
      end
      SPE_HV_PROG: begin
        // The high-voltage session lasts as long as the level stays up.
        if (!hvLevel) begin
          next_state = SPE_IDLE;
        end
      end
      SPE_LOCKED: begin
        if (mclrB) begin
          next_state = SPE_IDLE;
        end
      end
      default: begin
        next_state = SPE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= SPE_IDLE;
      keyShift <= '0;
      keyCount <= CNT_ZERO;
      sclkLast <= 1'b0;
      hvPrev   <= 1'b0;
    end else begin
      state    <= next_state;
      keyShift <= next_keyShift;
      keyCount <= next_keyCount;
      sclkLast <= sclk;
      hvPrev   <= hvLevel;
    end
  end

  // ==========================================================================
  // Session data path: bytes in, read bits out
  // ==========================================================================
  logic              inSession;
  logic [WORD_W-1:0] byteShift;
  logic [WORD_W-1:0] next_byteShift;
  logic [2:0]        bitCount;
  logic [2:0]        next_bitCount;
  logic              pushValid;
  logic              next_pushValid;
  logic [WORD_W-1:0] pushData;
  logic [WORD_W-1:0] next_pushData;
  logic              drive;
  logic              next_drive;
  logic              dataOut;
  logic              next_dataOut;
  logic              overflow;
  logic              next_overflow;

  spe_stream_if #(.WIDTH(WORD_W)) fifoIn  ();
  spe_stream_if #(.WIDTH(WORD_W)) fifoOut ();

  // Either way in, a session takes the same byte stream.
  assign inSession      = (state == SPE_LV_PROG) || (state == SPE_HV_PROG);
  assign fifoIn.data    = pushData;
  assign fifoIn.valid   = pushValid;
  // A word leaves only every other cycle, so each pulse stands alone for the sink.
  assign fifoOut.ready  = readyForWord && !progWordValid;

  always_comb begin
    next_byteShift = byteShift;
    next_bitCount  = bitCount;
    next_pushValid = pushValid && !fifoIn.ready;
    next_pushData  = pushData;
    next_overflow  = overflow;
    next_drive     = drive;
    next_dataOut   = dataOut;
    if (!inSession) begin
      next_bitCount  = BIT_ZERO;
      next_drive     = 1'b0;
      next_pushValid = 1'b0;
    end else if (readBitValid) begin
      // Receiving pauses while driving; the device never samples its own bits.
      // Device drives data line.
      next_drive   = 1'b1;
      next_dataOut = readBit;
    end else begin
      next_drive = 1'b0;
      if (sclkFall) begin
        next_byteShift = {sdat, byteShift[WORD_W-1:1]};
        next_bitCount  = bitCount + 3'h1;
        if (bitCount == BIT_LAST) begin
          // A full FIFO keeps what it holds; the newcomer is dropped and flagged.
          // Testing the FIFO itself, not the staging register, keeps the depth at
          // exactly sixteen bytes instead of one more.
          if (!fifoIn.ready) begin
            next_overflow = 1'b1;
          end else begin
            next_pushValid = 1'b1;
            next_pushData  = {sdat, byteShift[WORD_W-1:1]};
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      byteShift <= '0;
      bitCount  <= BIT_ZERO;
      pushValid <= 1'b0;
      pushData  <= '0;
      overflow  <= 1'b0;
      drive     <= 1'b0;
      dataOut   <= 1'b0;
    end else begin
      byteShift <= next_byteShift;
      bitCount  <= next_bitCount;
      pushValid <= next_pushValid;
      pushData  <= next_pushData;
      overflow  <= next_overflow;
      drive     <= next_drive;
      dataOut   <= next_dataOut;
    end
  end

  // The FIFO decouples the serial byte rate from the consumer, which may stall
  // for a whole burst of bytes without losing any up to the depth.
  spe_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .inPort   (fifoIn),
    .outPort  (fifoOut)
  );

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  logic              next_lowVoltageEntryClearOk;
  logic              next_masterClearResetEnable;
  logic              next_progMode;
  logic              next_progHighVoltage;
  logic [WORD_W-1:0] next_progWord;
  logic              next_progWordValid;
  logic              wordTaken;

  // Every pin-facing output leaves a flip-flop, so no decode glitch escapes.
  assign wordTaken = fifoOut.valid && fifoOut.ready;

  always_comb begin
    next_progWord               = progWord;
    next_progWordValid          = wordTaken;
    next_lowVoltageEntryClearOk = clearEntryEnableReq && (state == SPE_HV_PROG);
    next_masterClearResetEnable = low_voltage_entry_enable;
    next_progMode               = inSession;
    next_progHighVoltage        = (state == SPE_HV_PROG);
    if (wordTaken) begin
      next_progWord = fifoOut.data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_serial_data_out   <= 1'b0;
      prog_serial_data_oe_b  <= 1'b1;
      lowVoltageEntryClearOk <= 1'b0;
      masterClearResetEnable <= 1'b0;
      progMode               <= 1'b0;
      progHighVoltage        <= 1'b0;
      progWord               <= '0;
      progWordValid          <= 1'b0;
      progOverflow           <= 1'b0;
    end else begin
      prog_serial_data_out   <= dataOut;
      prog_serial_data_oe_b  <= !drive;
      lowVoltageEntryClearOk <= next_lowVoltageEntryClearOk;
      masterClearResetEnable <= next_masterClearResetEnable;
      progMode               <= next_progMode;
      progHighVoltage        <= next_progHighVoltage;
      progWord               <= next_progWord;
      progWordValid          <= next_progWordValid;
      progOverflow           <= overflow;
    end
  end

endmodule

// ===== hw/spe_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; depth is a power of two.
`timescale 1ns/10ps
module spe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  spe_stream_if.snk   inPort,
  spe_stream_if.src   outPort
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic [AW:0]      next_wrPtr;
  logic [AW:0]      next_rdPtr;
  logic             full;
  logic             empty;
  logic             doWrite;
  logic             doRead;

  assign full            = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty           = (wrPtr == rdPtr);
  assign inPort.ready    = !full;
  assign outPort.valid   = !empty;
  assign outPort.data    = mem[rdPtr[AW-1:0]];
  assign doWrite         = inPort.valid && !full;
  assign doRead          = outPort.ready && !empty;

  always_comb begin
    next_wrPtr = wrPtr + (AW+1)'(doWrite);
    next_rdPtr = rdPtr + (AW+1)'(doRead);
  end

  // One write port per entry, selected by the write index.
  for (genvar i = 0; i < DEPTH; i++) begin : gEntry
    always_comb begin
      next_mem[i] = mem[i];
      if (doWrite && (wrPtr[AW-1:0] == AW'(i))) begin
        next_mem[i] = inPort.data;
      end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        mem[i] <= '0;
      end else begin
        mem[i] <= next_mem[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end
endmodule

// ===== hw/spe_sync.sv
// Two-flip-flop synchroniser for pin inputs, one per bit.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/10ps
module spe_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1  <= '0;
      pinSync <= '0;
    end else begin
      stage1  <= pinIn;
      pinSync <= stage1;
    end
  end
endmodule

// ===== include/spe_pkg.sv
// Package for the serial programming entry block: key, widths, states.
// Assumes a single 25 MHz core clock and a programmer-driven serial clock pin.
package spe_pkg;

  // ==========================================================================
  // Widths and key
  // ==========================================================================
  localparam int          KEY_BITS   = 32;
  localparam int          CNT_W      = 6;
  localparam int          WORD_W     = 8;
  localparam int          FIFO_DEPTH = 16;
  // Entry key value; arbitrary, not tied to any real part.
  localparam logic [31:0] ENTRY_KEY  = 32'h5A3C_96E1;
  localparam logic [5:0]  KEY_LAST   = 6'h20;
  localparam logic [5:0]  CNT_ZERO   = 6'h00;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [2:0]  BIT_ZERO   = 3'h0;

  // ==========================================================================
  // Entry state machine, Gray coded along idle, key, session.
  // ==========================================================================
  typedef enum logic [2:0] {
    SPE_IDLE    = 3'b000,
    SPE_KEY     = 3'b001,
    SPE_LV_PROG = 3'b011,
    SPE_HV_PROG = 3'b010,
    SPE_LOCKED  = 3'b110
  } spe_state_t;

endpackage

// ===== include/spe_stream_if.sv
// Interface carrying a valid/ready word stream between block modules.
// Assumes both ends share core_clk.
`timescale 1ns/10ps
interface spe_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ===== tb/serial_programming_entry_bench.sv
// Self-checking bench for spe_entry against a queue model of the session bytes.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/10ps
module serial_programming_entry_bench;
  import spe_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        prog_serial_clock, progData, clearB, hvLevel, prog_serial_data_out;
  logic        prog_serial_data_oe_b, lowVoltageEntryClearOk, masterClearResetEnable;
  logic        progMode, progHighVoltage, progWordValid, progOverflow;
  logic        low_voltage_entry_enable = 1'b1;
  logic        clearEntryEnableReq = 1'b0;
  logic        readBitValid = 1'b0;
  logic        readBit = 1'b0;
  logic        readyForWord = 1'b0;
  logic        expOvf = 1'b0;
  logic [7:0]  progWord;
  logic [7:0]  expQ[$];
  logic [31:0] seed = 32'h0000_0030;
  int          num_errors = 0;
  int          comparisons = 0;
  wire         prog_serial_data_in = (prog_serial_data_oe_b === 1'b0) ? prog_serial_data_out
                                                                      : progData;

  always #20 core_clk = ~core_clk;
  spe_programmer u_spe_programmer (.prog_serial_clock, .progData, .clearPin_b(clearB),
    .hvLevel);
  spe_entry u_spe_entry (.core_clk, .rst_b, .prog_serial_clock, .prog_serial_data_in,
    .prog_serial_data_out, .prog_serial_data_oe_b, .master_clear_prog_voltage_pin_b(clearB),
    .high_voltage_entry_level(hvLevel), .low_voltage_entry_enable, .clearEntryEnableReq,
    .readBitValid, .readBit, .readyForWord, .lowVoltageEntryClearOk, .masterClearResetEnable,
    .progMode, .progHighVoltage, .progWord, .progWordValid, .progOverflow);

  // ==========================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check_bit(input string what, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic check_word(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_mode(input logic exp);
    int n;
    n = 0;
    while (progMode !== exp && n < 300) begin
      tick(1);
      n++;
    end
    check_bit("progMode", exp, progMode);
    if (progMode !== exp) end_of_test();
  endtask
  // The FIFO keeps the first sixteen bytes; a later one is dropped and flagged.
  task automatic send_byte();
    logic [7:0] b;
    b = 8'(rnd());
    if (expQ.size() < FIFO_DEPTH) expQ.push_back(b);
    else expOvf = 1'b1;
    u_spe_programmer.shift({24'h00_0000, b}, 8, 1'b0);
  endtask
  task automatic drain();
    int n;
    n = 0;
    readyForWord = 1'b1;
    while (expQ.size() > 0 && n < 400) begin
      tick(1);
      n++;
      if (progWordValid === 1'b1) check_word("progWord", expQ.pop_front(), progWord);
    end
    if (expQ.size() > 0) begin
      num_errors++;
      end_of_test();
    end
  endtask

  // ==========================
  // Scenarios
  initial begin
    tick(3);
    rst_b = 1'b1;
    check_bit("dataOe_b", 1'b1, prog_serial_data_oe_b);
    tick(3);
    u_spe_programmer.hv_enter();
    wait_mode(1'b1);
    check_bit("progHighVoltage", 1'b1, progHighVoltage);
    check_bit("resetForced", 1'b1, masterClearResetEnable);
    clearEntryEnableReq = 1'b1;
    tick(3);
    check_bit("clearOk", 1'b1, lowVoltageEntryClearOk);
    clearEntryEnableReq = 1'b0;
    for (int i = 0; i <= FIFO_DEPTH; i++) send_byte();
    tick(8);
    check_bit("progOverflow", expOvf, progOverflow);
    drain();
    u_spe_programmer.release_pins();
    wait_mode(1'b0);
    tick(3);
    low_voltage_entry_enable = 1'b0;
    tick(2);
    check_bit("resetForced", 1'b0, masterClearResetEnable);
    u_spe_programmer.lv_key(ENTRY_KEY);
    tick(20);
    check_bit("progMode", 1'b0, progMode);
    u_spe_programmer.release_pins();
    tick(3);
    low_voltage_entry_enable = 1'b1;
    tick(2);
    u_spe_programmer.lv_key(ENTRY_KEY);
    wait_mode(1'b1);
    check_bit("progHighVoltage", 1'b0, progHighVoltage);
    clearEntryEnableReq = 1'b1;
    tick(3);
    check_bit("clearOk", 1'b0, lowVoltageEntryClearOk);
    clearEntryEnableReq = 1'b0;
    readBit = 1'(rnd());
    readBitValid = 1'b1;
    tick(2);
    check_bit("dataOe_b", 1'b0, prog_serial_data_oe_b);
    check_bit("dataLine", readBit, prog_serial_data_in);
    readBitValid = 1'b0;
    tick(3);
    check_bit("dataOe_b", 1'b1, prog_serial_data_oe_b);
    u_spe_programmer.release_pins();
    wait_mode(1'b0);
    tick(3);
    u_spe_programmer.lv_key(ENTRY_KEY ^ (32'h0000_0001 << (rnd() % 32)));
    tick(20);
    check_bit("progMode", 1'b0, progMode);
    u_spe_programmer.shift(ENTRY_KEY, 32, 1'b1);
    tick(20);
    check_bit("progMode", 1'b0, progMode);
    u_spe_programmer.release_pins();
    end_of_test();
  end
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end
endmodule

// ===== tb/spe_entry_asserts.sv
// Port checks for the serial programming entry block.
// Bound to spe_entry; everything runs on core_clk.
`timescale 1ns/10ps
module spe_entry_asserts (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       prog_serial_clock,
  input wire logic       prog_serial_data_in,
  input wire logic       prog_serial_data_out,
  input wire logic       prog_serial_data_oe_b,
  input wire logic       master_clear_prog_voltage_pin_b,
  input wire logic       high_voltage_entry_level,
  input wire logic       low_voltage_entry_enable,
  input wire logic       clearEntryEnableReq,
  input wire logic       readBitValid,
  input wire logic       readBit,
  input wire logic       readyForWord,
  input wire logic       lowVoltageEntryClearOk,
  input wire logic       masterClearResetEnable,
  input wire logic       progMode,
  input wire logic       progHighVoltage,
  input wire logic [7:0] progWord,
  input wire logic       progWordValid,
  input wire logic       progOverflow
);
  // ==========================
  // Properties
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  chk_reset_forced: assert property (
    1'b1 |=> masterClearResetEnable == $past(low_voltage_entry_enable)) else $error("force");
  chk_lv_gated: assert property (
    $rose(progMode) && !progHighVoltage |-> $past(masterClearResetEnable)) else $error("lv gate");
  chk_lv_session_end: assert property (
    $rose(master_clear_prog_voltage_pin_b) && progMode && !progHighVoltage |-> ##[1:6] !progMode)
    else $error("lv end");
  chk_hv_entry: assert property (
    $rose(high_voltage_entry_level) && !progMode && !prog_serial_clock && !prog_serial_data_in
    |-> ##[1:8] progMode && progHighVoltage) else $error("hv entry");
  chk_clear_grant: assert property (
    lowVoltageEntryClearOk |-> progHighVoltage && $past(clearEntryEnableReq))
    else $error("clear grant");
  chk_read_drive: assert property (
    progMode && readBitValid ##1 progMode |=> !prog_serial_data_oe_b &&
    prog_serial_data_out == $past(readBit, 2))
    else $error("read drive");
  chk_word_gap: assert property (
    progWordValid |=> !progWordValid) else $error("word gap");
  chk_overflow_sticky: assert property (
    progOverflow |=> progOverflow) else $error("overflow");
  cover property ($rose(progMode) && progHighVoltage);
  cover property ($rose(progMode) && !progHighVoltage);
  cover property ($rose(progOverflow));
endmodule
bind spe_entry spe_entry_asserts u_spe_entry_asserts (.core_clk, .rst_b, .prog_serial_clock,
  .prog_serial_data_in, .prog_serial_data_out, .prog_serial_data_oe_b,
  .master_clear_prog_voltage_pin_b, .high_voltage_entry_level, .low_voltage_entry_enable,
  .clearEntryEnableReq, .readBitValid, .readBit, .readyForWord, .lowVoltageEntryClearOk,
  .masterClearResetEnable, .progMode, .progHighVoltage, .progWord, .progWordValid,
  .progOverflow);

// ===== tb/spe_programmer.sv
// Programmer model: drives the serial clock, data and entry pins.
// Assumes the bench resolves the shared data line.
`timescale 1ns/10ps
module spe_programmer (
  output logic prog_serial_clock,
  output logic progData,
  output logic clearPin_b,
  output logic hvLevel
);
  initial begin
    prog_serial_clock = 1'b0;
    progData = 1'b0;
    clearPin_b = 1'b1;
    hvLevel = 1'b0;
  end
  // ==========================
  // Pin sequences
  // Clock driven only here.
  // Data moves 80 ns after a fall so it never races the sampling edge.
  task automatic shift(input logic [31:0] val, input int n, input bit msb);
    for (int i = 0; i < n; i++) begin
      progData = msb ? val[n-1-i] : val[i];
      #80 prog_serial_clock = 1'b1;
      #160 prog_serial_clock = 1'b0;
      #80;
    end
  endtask
  task automatic hv_enter();
    progData = 1'b0;
    #213 hvLevel = 1'b1;
  endtask
  task automatic lv_key(input logic [31:0] key);
    clearPin_b = 1'b0;
    #213 shift(key, 32, 1'b1);
  endtask
  task automatic release_pins();
    hvLevel = 1'b0;
    clearPin_b = 1'b1;
    #400;
  endtask
endmodule
